// file: rtl/wdw_watchdog_window.sv
/*
 * Windowed watchdog timer with AHB-Lite register access.
 * Assumes the CPU core drives one-cycle instruction and clock-switch
 * pulses on clk, and that wdtResetReq is fed back into rst by the
 * system reset controller.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - RC clock at 32 kHz, enabled whenever watchdog enabled.
// - Prescaler divides RC clock by 32 or by 128 per select bit.
// - Prescaler alone gives 1 ms or 4 ms at 32 kHz.
// - Postscaler 4-bit field picks one of 16 ratios, 1:1 to 1:32,768.
// - Device reset clears counter, prescaler and postscaler.
// - Completed clock switch, software or fail-safe, clears all counts.
// - Power-save instruction entering sleep or idle clears all counts.
// - Leaving sleep or idle clears all counts.
// - Clear instruction in normal execution clears all counts.
// - Watchdog counts in sleep and idle; timeout wakes the device.
// - Timeout flag is cleared only by device reset or by software write.
// - Forced-enable configuration bit runs the watchdog unconditionally.
// - Without forced enable, software enable bit turns watchdog on or off.
// - Software enable bit clears on any device reset.
// - Window mode: clear before final quarter causes watchdog reset.
// - Prescale select 1 means 1:128, 0 means 1:32.
// - Postscale code n gives ratio 2^n; 1111 is 1:32,768.
// - Window-disable 1 selects non-window, 0 selects window mode.
module wdw_watchdog_window
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core events, one-cycle pulses
    input wire logic clearInstr,
    input wire logic powerSaveInstr,
    input wire logic powerSaveIdle,
    input wire logic wakeEvent,
    input wire logic clkSwitchDone,
    // Outputs to clock and reset control
    output logic lprcEnable,
    output logic wdtResetReq,
    output logic wakeReq
);
    import wdw_pkg::*;

    // Total period in RC ticks for a given configuration
    function automatic logic [ELAPSED_W-1:0] periodOf(input wdw_cfg_s c);
        logic [4:0] shamt;
        shamt = (c.prescaleSelect ? 5'(PRE_LONG_LOG2) : 5'(PRE_SHORT_LOG2))
            + {1'b0, c.postscaleSelect};
        periodOf = ELAPSED_W'(1) << shamt;
    endfunction : periodOf

    wdw_cfg_s cfg_r;
    wdw_pm_e pm_r;
    wdw_pm_e pm_nxt;
    logic swEnable_r;
    logic timeoutFlag_r;
    logic sleepFlag_r;
    logic idleFlag_r;
    logic [LOW_POWER_RC_OSC_DIV_W-1:0] lprcDiv_r;
    logic [ELAPSED_W-1:0] elapsed_r;
    logic wrPend_r;
    logic [11:0] wrAddr_r;
    logic [31:0] hrdata_r;
    logic wdtResetReq_r;
    logic wakeReq_r;

    // Enable and RC tick
    logic wdtEnabled;
    logic lprcTick;
    logic [ELAPSED_W-1:0] period;
    logic [ELAPSED_W-1:0] windowStart;
    logic inRun;
    logic timeoutHit;
    logic windowFault;
    logic leavePowerSave;
    logic enterPowerSave;
    logic runClear;
    logic countClear;

    assign wdtEnabled = cfg_r.forcedEnable | swEnable_r;
    assign lprcEnable = wdtEnabled;
    assign lprcTick = wdtEnabled && (lprcDiv_r == LOW_POWER_RC_OSC_DIV_W'(LOW_POWER_RC_OSC_TICK_CYCLES - 1));

    assign period = periodOf(cfg_r);
    // Final quarter starts at three quarters of the period
    assign windowStart = period - (period >> 2);
    assign inRun = (pm_r == PM_RUN);

    // prescaler and postscaler as one count
    // 32 or 128 ticks per prescaler step
    assign timeoutHit = lprcTick && (elapsed_r == period - ELAPSED_W'(1));

    assign windowFault = clearInstr && inRun && wdtEnabled
        && !cfg_r.windowDisable && (elapsed_r < windowStart);

    assign enterPowerSave = powerSaveInstr && inRun;
    // timeout in sleep or idle wakes the device
    assign leavePowerSave = !inRun && (wakeEvent || timeoutHit);
    assign runClear = clearInstr && inRun;

    assign countClear = clkSwitchDone || enterPowerSave || leavePowerSave
        || runClear || timeoutHit;

    // Power mode sequencing
    always_comb
    begin
        pm_nxt = pm_r;
        case (pm_r)
            PM_RUN:
            begin
                if (powerSaveInstr)
                begin
                    pm_nxt = powerSaveIdle ? PM_IDLE : PM_SLEEP;
                end
            end
            PM_SLEEP, PM_IDLE:
            begin
                if (wakeEvent || timeoutHit)
                begin
                    pm_nxt = PM_RUN;
                end
            end
            default:
            begin
                pm_nxt = PM_RUN;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pm_r <= PM_RUN;
        end
        else
        begin
            pm_r <= pm_nxt;
        end
    end

    // The divider stands for the RC oscillator; it stops when disabled
    always_ff @(posedge clk)
    begin
        if (rst || lprcTick || !wdtEnabled)
        begin
            lprcDiv_r <= '0;
        end
        else
        begin
            lprcDiv_r <= lprcDiv_r + LOW_POWER_RC_OSC_DIV_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || countClear || !wdtEnabled)
        begin
            elapsed_r <= '0;
        end
        else if (lprcTick)
        begin
            elapsed_r <= elapsed_r + ELAPSED_W'(1);
        end
    end

    // timeout in run mode resets the device
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wdtResetReq_r <= 1'b0;
            wakeReq_r <= 1'b0;
        end
        else
        begin
            wdtResetReq_r <= (timeoutHit && inRun) || windowFault;
            wakeReq_r <= timeoutHit && !inRun;
        end
    end

    assign wdtResetReq = wdtResetReq_r;
    assign wakeReq = wakeReq_r;

    // AHB-Lite: zero wait states, always OKAY
    logic accept;
    logic wrRc;
    logic wrCfg;
    logic [11:0] rdAddr;
    logic [31:0] rcWord;
    logic [31:0] statWord;
    logic [31:0] rdWord;

    assign accept = hsel && htrans[1] && hready;
    assign rdAddr = haddr[11:0];
    assign wrRc = wrPend_r && (wrAddr_r == ADDR_RESET_CAUSE);
    assign wrCfg = wrPend_r && (wrAddr_r == ADDR_CONFIG);

    assign rcWord = (32'(swEnable_r) << RC_SWEN_BIT)
        | (32'(timeoutFlag_r) << RC_TIMEOUT_BIT)
        | (32'(sleepFlag_r) << RC_SLEEP_BIT)
        | (32'(idleFlag_r) << RC_IDLE_BIT);
    assign statWord = (32'(wdtEnabled) << STAT_EN_BIT)
        | (32'(pm_r) << STAT_MODE_LSB)
        | 32'(elapsed_r);
    assign rdWord = (rdAddr == ADDR_RESET_CAUSE) ? rcWord
        : (rdAddr == ADDR_CONFIG) ? {24'h00_0000, cfg_r}
        : (rdAddr == ADDR_STATUS) ? statWord
        : 32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 12'h000;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            wrPend_r <= accept && hwrite;
            if (accept)
            begin
                wrAddr_r <= rdAddr;
            end
            if (accept && !hwrite)
            begin
                hrdata_r <= rdWord;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Configuration word; spare bit always reads zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_r <= wdw_cfg_s'(CFG_RESET);
        end
        else if (wrCfg)
        begin
            cfg_r <= wdw_cfg_s'(hwdata[7:0] & 8'hDF);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            swEnable_r <= 1'b0;
        end
        else if (wrRc)
        begin
            swEnable_r <= hwdata[RC_SWEN_BIT];
        end
    end

    // Status flags: a hardware set wins over a software write in the same cycle
    logic toSet;
    assign toSet = timeoutHit || windowFault;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            timeoutFlag_r <= 1'b0;
            sleepFlag_r <= 1'b0;
            idleFlag_r <= 1'b0;
        end
        else
        begin
            // only a software write or device reset clears the timeout flag
            timeoutFlag_r <= toSet || (wrRc ? hwdata[RC_TIMEOUT_BIT] : timeoutFlag_r);
            // mode flags stay until software clears them
            sleepFlag_r <= (enterPowerSave && !powerSaveIdle)
                || (wrRc ? hwdata[RC_SLEEP_BIT] : sleepFlag_r);
            idleFlag_r <= (enterPowerSave && powerSaveIdle)
                || (wrRc ? hwdata[RC_IDLE_BIT] : idleFlag_r);
        end
    end

endmodule : wdw_watchdog_window

`default_nettype wire

// file: rtl/wdw_pkg.sv
/*
 * Shared constants and types of the windowed watchdog: clock rates, prescaler
 * ratios, register offsets, field positions and reset values.
 * Assumes a single 20 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package wdw_pkg;

    // Clock rates
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int LOW_POWER_RC_OSC_FREQ_HZ = 32_000;
    localparam int LOW_POWER_RC_OSC_TICK_CYCLES = CLK_FREQ_HZ / LOW_POWER_RC_OSC_FREQ_HZ;
    localparam int LOW_POWER_RC_OSC_DIV_W = 10;

    // Prescaler timeouts and the ratios they imply at the RC rate
    localparam int PRE_SHORT_TIMEOUT_US = 1000;
    localparam int PRE_LONG_TIMEOUT_US = 4000;
    localparam int PRE_SHORT_RATIO = PRE_SHORT_TIMEOUT_US * LOW_POWER_RC_OSC_FREQ_HZ / 1_000_000;
    localparam int PRE_LONG_RATIO = PRE_LONG_TIMEOUT_US * LOW_POWER_RC_OSC_FREQ_HZ / 1_000_000;
    localparam int PRE_SHORT_LOG2 = $clog2(PRE_SHORT_RATIO);
    localparam int PRE_LONG_LOG2 = $clog2(PRE_LONG_RATIO);

    // Prescaler plus postscaler count: up to 2^7 * 2^15 ticks
    localparam int ELAPSED_W = 23;

    // Register byte offsets (low address bits only)
    localparam logic [11:0] ADDR_RESET_CAUSE = 12'h000;
    localparam logic [11:0] ADDR_CONFIG = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;

    // Reset-cause register fields
    localparam int RC_SWEN_BIT = 5;
    localparam int RC_TIMEOUT_BIT = 4;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_IDLE_BIT = 2;

    // Status register fields
    localparam int STAT_MODE_LSB = 24;
    localparam int STAT_EN_BIT = 28;

    // Configuration word layout, bits 7..0
    typedef struct packed {
        logic forcedEnable;
        logic windowDisable;
        logic spare;
        logic prescaleSelect;
        logic [3:0] postscaleSelect;
    } wdw_cfg_s;

    // Non-window, software enabled, 1:32 prescale, 1:32,768 postscale
    localparam logic [7:0] CFG_RESET = 8'h4F;

    typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_IDLE} wdw_pm_e;

endpackage : wdw_pkg

// file: verif/wdw_watchdog_window_assertions.sv
/* Checker of the windowed watchdog outputs, bound into the top module.
   Assumes the top module's port names and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wdw_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events and outputs
    input wire logic clearInstr,
    input wire logic powerSaveInstr,
    input wire logic lprcEnable,
    input wire logic wdtResetReq,
    input wire logic wakeReq
);
    import wdw_pkg::*;
    // Tick phase is unknown, so only 31 whole ticks are certain
    localparam int MIN_GAP = 31 * LOW_POWER_RC_OSC_TICK_CYCLES;
    logic [16:0] gap_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
    begin
        if (rst || !lprcEnable || wdtResetReq || wakeReq)
            gap_r <= 17'h0;
        else if (gap_r < 17'(MIN_GAP))
            gap_r <= gap_r + 17'h1;
    end
    a_rst_quiet: assert property ($fell(rst) |-> (!wdtResetReq && !wakeReq) [*3])
        else $error("timeout pulse right after reset");
    a_rst_rc_off: assert property ($fell(rst) |-> !lprcEnable)
        else $error("oscillator on after reset");
    a_reset_needs_rc: assert property (wdtResetReq |-> $past(lprcEnable))
        else $error("reset request while disabled");
    a_wake_needs_rc: assert property (wakeReq |-> $past(lprcEnable))
        else $error("wake request while disabled");
    a_one_cause: assert property (wdtResetReq |-> !wakeReq)
        else $error("reset and wake together");
    a_clear_restarts: assert property (clearInstr |=> (!wdtResetReq || $past(clearInstr)) [*8])
        else $error("timeout just after a clear");
    a_psave_quiet: assert property (powerSaveInstr |-> ##2 (!wdtResetReq || $past(clearInstr)) [*6])
        else $error("reset request after power save");
    a_min_period: assert property ((wdtResetReq || wakeReq) && !$past(clearInstr) |-> gap_r >= 17'(MIN_GAP))
        else $error("timeout earlier than shortest period");
    c_timeout: cover property (wdtResetReq && !$past(clearInstr));
    c_wake: cover property (wakeReq);
    c_fault: cover property (clearInstr ##[1:2] wdtResetReq);
endmodule : wdw_chk
bind wdw_watchdog_window wdw_chk i_chk (.clk(clk), .rst(rst), .clearInstr(clearInstr),
    .powerSaveInstr(powerSaveInstr), .lprcEnable(lprcEnable), .wdtResetReq(wdtResetReq),
    .wakeReq(wakeReq));
`default_nettype wire

// file: verif/wdw_watchdog_window_tb_top.sv
/* Self-checking bench of the windowed watchdog.
   Assumes nothing feeds wdtResetReq back into rst. */
`timescale 1ns/1ps
`default_nettype none
module wdw_watchdog_window_tb_top;
    import wdw_pkg::*;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, psIdle = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [3:0] ev = 4'h0;
    wire logic hreadyout, hresp, lprcEnable, wdtResetReq, wakeReq;
    wire logic [31:0] hrdata;
    int failCount = 0, nCompared = 0, seed = 32'h8652_1d07, n, lim;
    wdw_watchdog_window i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .clearInstr(ev[3]), .powerSaveInstr(ev[2]), .powerSaveIdle(psIdle),
        .wakeEvent(ev[1]), .clkSwitchDone(ev[0]), .lprcEnable(lprcEnable),
        .wdtResetReq(wdtResetReq), .wakeReq(wakeReq));
    always #25 clk = ~clk;
    function automatic int per(input logic pre, input logic [3:0] post);
        return ((pre ? 128 : 32) << post) * LOW_POWER_RC_OSC_TICK_CYCLES;
    endfunction : per
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            failCount++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkT(input int lo, input int hi);
        nCompared++;
        if (n < lo || n > hi)
        begin
            failCount++;
            $display("unexpected at %0t: waited %0d, not %0d..%0d", $time, n, lo, hi);
        end
    endtask : chkT
    // Counts edges until the chosen pulse is seen or the limit runs out
    task automatic waitOut(input logic wk, input int lim);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((wk ? wakeReq : wdtResetReq) !== 1'b1 && n < lim);
    endtask : waitOut
    task automatic evt(input logic [3:0] e);
        ev <= e;
        @(posedge clk);
        ev <= 4'h0;
    endtask : evt
    task automatic finishTest;
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finishTest
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h0); // software enable starts clear
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, {24'h00_0000, CFG_RESET}); // starts in non-window mode
        bus(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, lprcEnable}, 32'h0); // oscillator off while disabled
        chk({31'h0, hresp}, 32'h0); // bus answers OKAY after reset
        bus(1'b1, ADDR_CONFIG, 32'h40);
        bus(1'b1, ADDR_RESET_CAUSE, 32'h20);
        #1;
        chk({31'h0, lprcEnable}, 32'h1); // software enable
        waitOut(1'b0, 30000);
        chkT(per(1'b0, 4'h0) - LOW_POWER_RC_OSC_TICK_CYCLES, per(1'b0, 4'h0) + 4); // shortest period
        repeat (50) @(posedge clk);
        bus(1'b0, ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h30); // flag stays set
        bus(1'b1, ADDR_RESET_CAUSE, 32'h0);
        #1;
        chk({31'h0, lprcEnable}, 32'h0); // software disable
        bus(1'b1, ADDR_CONFIG, 32'hC0);
        #1;
        chk({31'h0, lprcEnable}, 32'h1); // forced on
        for (int i = 0; i < 4; i++)
        begin
            lim = 3000 + ($random(seed) & 32'h03FF);
            waitOut(1'b0, lim);
            chkT(lim, lim); // serviced, no timeout
            evt(i[0] ? 4'h8 : 4'h1); // switch or clear restarts
        end
        bus(1'b1, ADDR_CONFIG, 32'h80);
        evt(4'h8);
        waitOut(1'b0, 3);
        chkT(1, 2); // early clear faults
        bus(1'b0, ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h10); // fault sets the flag
        evt(4'h1);
        waitOut(1'b0, 17000);
        chkT(17000, 17000); // switch restarts count
        evt(4'h8); // clear only in the last quarter
        waitOut(1'b0, 8);
        chkT(8, 8); // clear in window accepted
        // Same clear time is early once the prescaler divides by 128
        bus(1'b1, ADDR_CONFIG, 32'h90);
        evt(4'h1);
        waitOut(1'b0, 17000);
        chkT(17000, 17000); // long prescale, no timeout yet
        evt(4'h8);
        waitOut(1'b0, 3);
        chkT(1, 2); // select 1 means 1:128
        bus(1'b1, ADDR_CONFIG, 32'h80);
        bus(1'b1, ADDR_RESET_CAUSE, 32'h0);
        psIdle <= 1'b1;
        evt(4'h4);
        bus(1'b0, ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h4); // idle entered
        repeat (5000) @(posedge clk);
        evt(4'h2);
        bus(1'b1, ADDR_RESET_CAUSE, 32'h0);
        psIdle <= 1'b0;
        evt(4'h4);
        waitOut(1'b1, 30000);
        chkT(per(1'b0, 4'h0) - LOW_POWER_RC_OSC_TICK_CYCLES, per(1'b0, 4'h0) + 4); // wakes sleep
        bus(1'b0, ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h18); // sleep and timeout flags
        finishTest();
    end
    // About 96k cycles of tests at most, so this only cuts a hang
    initial
    begin
        repeat (99000) @(posedge clk);
        failCount++;
        $display("unexpected at %0t: run did not finish", $time);
        finishTest();
    end
endmodule : wdw_watchdog_window_tb_top
`default_nettype wire
